// file: core/lscs_pkg.sv
// Constants and carrier types for the LED sink current settings bank.
// Assumes a serial control front end that presents decoded byte accesses
// on ref_clk, and downstream analog sink drivers that take codes and enables.
package lscs_pkg;

   localparam int LSCS_ADDR_W = 8;
   localparam int LSCS_DATA_W = 8;
   localparam int LSCS_UA_W = 18;
   localparam int LSCS_NUM_REGS = 5;
   localparam int LSCS_NUM_AUX = 3;
   localparam int LSCS_NUM_FLASH = 3;

   // Register offsets
   localparam logic [7:0] LSCS_OFS_FLASH_PREVIEW = 8'h01;
   localparam logic [7:0] LSCS_OFS_FLASH_STROBE = 8'h02;
   localparam logic [7:0] LSCS_OFS_AUX_A = 8'h06;
   localparam logic [7:0] LSCS_OFS_AUX_B = 8'h07;
   localparam logic [7:0] LSCS_OFS_AUX_C = 8'h08;

   // Index of each register inside the storage array
   localparam logic [2:0] LSCS_IDX_FLASH_PREVIEW = 3'h0;
   localparam logic [2:0] LSCS_IDX_FLASH_STROBE = 3'h1;
   localparam logic [2:0] LSCS_IDX_AUX_A = 3'h2;
   localparam logic [2:0] LSCS_IDX_AUX_B = 3'h3;
   localparam logic [2:0] LSCS_IDX_AUX_C = 3'h4;
   localparam logic [2:0] LSCS_IDX_NONE = 3'h7;

   // Reset value, unmapped read value and code end points
   localparam logic [7:0] LSCS_LEVEL_RESET = 8'h00;
   localparam logic [7:0] LSCS_UNMAPPED_READ = 8'h00;
   localparam logic [7:0] LSCS_CODE_ZERO = 8'h00;
   localparam logic [7:0] LSCS_CODE_FULL = 8'hFF;

   // Current scale: full-scale code gives 160mA, total pump limit 480mA
   localparam int LSCS_FULL_SCALE_MA = 160;
   localparam int LSCS_PUMP_LIMIT_MA = 480;
   localparam int LSCS_FULL_SCALE_UA = LSCS_FULL_SCALE_MA * 1000;
   localparam int LSCS_CODE_STEPS = 255;

   // Pin synchroniser depth
   localparam int LSCS_SYNC_STAGES = 3;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [LSCS_ADDR_W-1:0] addr;
      logic [LSCS_DATA_W-1:0] wdata;
   } lscs_req_t;

   typedef struct packed {
      logic valid;
      logic [LSCS_DATA_W-1:0] data;
   } lscs_rsp_t;

   typedef struct packed {
      logic on;
      logic [LSCS_DATA_W-1:0] level;
      logic [LSCS_UA_W-1:0] ua;
   } lscs_sink_t;

   typedef struct packed {
      logic preview_enable;
      logic preview_pin_select;
      logic aux_sinks_pin0_gate;
      logic aux_sinks_strobe_gate;
      logic strobe_active;
   } lscs_ctrl_t;

endpackage

// file: core/lscs_sync.sv
// Three-stage synchroniser with agreement filter for an external pin.
// Assumes the pin is asynchronous to ref_clk; level changes only when the
// second and third stages agree.
`timescale 1ns/1ps
module lscs_sync
   import lscs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic pin_async,
   output logic pin_level
);

   typedef struct packed {
      logic ff1;
      logic ff2;
      logic ff3;
      logic level;
   } lscs_sync_state_t;

   lscs_sync_state_t st;
   lscs_sync_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.ff1 = pin_async;
      next_st.ff2 = st.ff1;
      next_st.ff3 = st.ff2;
      // Only the later two stages are compared; ff1 may be metastable
      if (st.ff2 == st.ff3) begin
         next_st.level = st.ff3;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pin_level = st.level;

endmodule // lscs_sync

// file: core/lscs_top.sv
// Current-setting register bank for the flash and auxiliary LED sinks.
// Assumes a serial control front end delivering byte accesses on ref_clk,
// strobe timing and mode bits from neighbouring logic on the same clock,
// and pin0 arriving asynchronously from the package pin.
`timescale 1ns/1ps
module lscs_top
   import lscs_pkg::*;
#(
   parameter int NUM_AUX = LSCS_NUM_AUX
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire lscs_req_t reg_req,
   output lscs_rsp_t reg_rsp,
   input wire lscs_ctrl_t ctrl,
   input wire logic general_pin0_preview_input,
   output lscs_sink_t flash_sink_a,
   output lscs_sink_t flash_sink_b,
   output lscs_sink_t flash_sink_c,
   output lscs_sink_t aux_sink_a,
   output lscs_sink_t aux_sink_b,
   output lscs_sink_t aux_sink_c,
   output logic [LSCS_UA_W-1:0] flash_total_ua
);

   typedef struct packed {
      logic [LSCS_NUM_REGS-1:0][LSCS_DATA_W-1:0] level;
      lscs_rsp_t rsp;
      lscs_sink_t flash;
      logic [LSCS_UA_W-1:0] flash_total;
      logic [LSCS_NUM_AUX-1:0] aux_on;
      logic [LSCS_NUM_AUX-1:0][LSCS_DATA_W-1:0] aux_level;
      logic [LSCS_NUM_AUX-1:0][LSCS_UA_W-1:0] aux_ua;
   } lscs_state_t;

   lscs_state_t st;
   lscs_state_t next_st;
   logic pin0_level;

   // Map a register offset to its storage index
   function automatic logic [2:0] lscs_index(input logic [LSCS_ADDR_W-1:0] addr);
      logic [2:0] idx;
      idx = LSCS_IDX_NONE;
      unique case (addr)
         LSCS_OFS_FLASH_PREVIEW: idx = LSCS_IDX_FLASH_PREVIEW;
         LSCS_OFS_FLASH_STROBE: idx = LSCS_IDX_FLASH_STROBE;
         LSCS_OFS_AUX_A: idx = LSCS_IDX_AUX_A;
         LSCS_OFS_AUX_B: idx = LSCS_IDX_AUX_B;
         LSCS_OFS_AUX_C: idx = LSCS_IDX_AUX_C;
         default: idx = LSCS_IDX_NONE;
      endcase
      return idx;
   endfunction

   // Linear code-to-current map in microamps, split over a number of sinks
   function automatic logic [LSCS_UA_W-1:0] lscs_to_ua(
      input logic [LSCS_DATA_W-1:0] code,
      input int share
   );
      int unsigned prod;
      prod = 0;
      prod = 32'(code) * 32'(LSCS_FULL_SCALE_UA);
      return LSCS_UA_W'(prod / 32'(LSCS_CODE_STEPS * share));
   endfunction

   lscs_sync u_pin0_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin_async(general_pin0_preview_input),
      .pin_level(pin0_level)
   );

   logic preview_active;
   logic [LSCS_DATA_W-1:0] flash_code;
   logic aux_gated;
   logic aux_gate_open;

   always_comb begin
      logic [2:0] widx;
      logic [2:0] ridx;
      widx = lscs_index(reg_req.addr);
      ridx = widx;
      next_st = st;

      // Byte writes; unmapped offsets are dropped
      if (reg_req.wr && widx != LSCS_IDX_NONE) begin
         next_st.level[widx] = reg_req.wdata;
      end

      // Reads return the stored code one cycle later; unmapped read as zero
      next_st.rsp.valid = reg_req.rd;
      if (reg_req.rd) begin
         if (ridx != LSCS_IDX_NONE) begin
            next_st.rsp.data = st.level[ridx];
         end else begin
            next_st.rsp.data = LSCS_UNMAPPED_READ;
         end
      end

      // Preview source: pin0 when selected, otherwise the enable bit
      if (ctrl.preview_pin_select) begin
         preview_active = pin0_level;
      end else begin
         preview_active = ctrl.preview_enable;
      end

      // Strobe takes precedence over preview while it runs
      if (ctrl.strobe_active) begin
         flash_code = st.level[LSCS_IDX_FLASH_STROBE];
      end else if (preview_active) begin
         flash_code = st.level[LSCS_IDX_FLASH_PREVIEW];
      end else begin
         flash_code = LSCS_CODE_ZERO;
      end

      // One shared setting drives all three flash sinks
      next_st.flash.on = flash_code != LSCS_CODE_ZERO;
      next_st.flash.level = flash_code;
      next_st.flash.ua = lscs_to_ua(flash_code, LSCS_NUM_FLASH);
      next_st.flash_total = lscs_to_ua(flash_code, 1);

      // Gating adds an open-gate condition to the nonzero-code activation of the aux sinks
      aux_gated = ctrl.aux_sinks_pin0_gate || ctrl.aux_sinks_strobe_gate;
      aux_gate_open = (ctrl.aux_sinks_pin0_gate && pin0_level) ||
                      (ctrl.aux_sinks_strobe_gate && ctrl.strobe_active);

      for (int i = 0; i < LSCS_NUM_AUX; i++) begin
         next_st.aux_level[i] = st.level[LSCS_IDX_AUX_A + 3'(i)];
         next_st.aux_ua[i] = lscs_to_ua(st.level[LSCS_IDX_AUX_A + 3'(i)], 1);
         if (aux_gated) begin
            next_st.aux_on[i] = aux_gate_open &&
                                (st.level[LSCS_IDX_AUX_A + 3'(i)] != LSCS_CODE_ZERO);
         end else begin
            next_st.aux_on[i] = st.level[LSCS_IDX_AUX_A + 3'(i)] != LSCS_CODE_ZERO;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from the state register
   assign reg_rsp = st.rsp;
   assign flash_sink_a = st.flash;
   assign flash_sink_b = st.flash;
   assign flash_sink_c = st.flash;
   assign flash_total_ua = st.flash_total;
   assign aux_sink_a = '{on: st.aux_on[0], level: st.aux_level[0], ua: st.aux_ua[0]};
   assign aux_sink_b = '{on: st.aux_on[1], level: st.aux_level[1], ua: st.aux_ua[1]};
   assign aux_sink_c = '{on: st.aux_on[2], level: st.aux_level[2], ua: st.aux_ua[2]};

   // Load limit is software's duty; the bank does not clip codes.
   // Summed flash sink current is exposed on flash_total_ua so a monitor can flag overload.

   // ---------------- Assertions ----------------
   default clocking lscs_cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   // The host never issues a write and a read back to back, so store and readback
   // are guarded separately
   a_preview_write_lands: assert property (
      reg_req.wr && reg_req.addr == LSCS_OFS_FLASH_PREVIEW
      |=> st.level[LSCS_IDX_FLASH_PREVIEW] == $past(reg_req.wdata))
      else $error("preview level write not stored");

   a_preview_read_back: assert property (
      reg_req.rd && reg_req.addr == LSCS_OFS_FLASH_PREVIEW
      |=> reg_rsp.valid && reg_rsp.data == $past(st.level[LSCS_IDX_FLASH_PREVIEW]))
      else $error("preview level readback differs from stored value");

   a_strobe_level_used: assert property (
      ctrl.strobe_active && !reg_req.wr
      |-> ##1 flash_sink_a.level == $past(st.level[LSCS_IDX_FLASH_STROBE]))
      else $error("strobe does not apply strobe level");

   a_aux_a_nonzero_on: assert property (
      !aux_gated && st.level[LSCS_IDX_AUX_A] != LSCS_CODE_ZERO
      |=> aux_sink_a.on)
      else $error("aux sink a not enabled by nonzero code");

   a_aux_b_zero_off: assert property (
      st.level[LSCS_IDX_AUX_B] == LSCS_CODE_ZERO |=> !aux_sink_b.on)
      else $error("aux sink b on with zero code");

   a_aux_c_follows_code: assert property (
      reg_req.wr && reg_req.addr == LSCS_OFS_AUX_C && !aux_gated
      ##1 !aux_gated && !reg_req.wr
      |=> aux_sink_c.on == ($past(reg_req.wdata, 2) != LSCS_CODE_ZERO))
      else $error("aux sink c enable does not follow written code");

   a_gate_blocks_aux: assert property (
      aux_gated && !aux_gate_open |=> !aux_sink_a.on && !aux_sink_b.on && !aux_sink_c.on)
      else $error("aux sinks enabled while gate closed");

   a_flash_shared: assert property (
      flash_sink_a == flash_sink_b && flash_sink_b == flash_sink_c)
      else $error("flash sinks differ");

   a_flash_third_share: assert property (
      flash_sink_a.ua <= flash_total_ua / 3 &&
      flash_sink_a.ua + 1 >= flash_total_ua / 3)
      else $error("flash sink not one third of total");

   a_preview_bit_off: assert property (
      !ctrl.preview_pin_select && !ctrl.preview_enable && !ctrl.strobe_active
      |=> flash_total_ua == '0 && !flash_sink_a.on)
      else $error("flash current with preview off");

   a_pin_preview_src: assert property (
      ctrl.preview_pin_select && !ctrl.strobe_active && !pin0_level
      |=> !flash_sink_a.on)
      else $error("flash on while pin0 preview low");

   a_full_scale_map: assert property (
      aux_sink_a.level == LSCS_CODE_FULL |-> aux_sink_a.ua == LSCS_UA_W'(LSCS_FULL_SCALE_UA))
      else $error("full scale code does not give full scale current");

   a_unmapped_zero: assert property (
      reg_req.rd && lscs_index(reg_req.addr) == LSCS_IDX_NONE
      |=> reg_rsp.valid && reg_rsp.data == LSCS_UNMAPPED_READ)
      else $error("unmapped read not zero");

endmodule // lscs_top

// file: bench/lscs_host.sv
// Host model driving byte accesses into the sink current bank.
// Assumes requests launch just after ref_clk rising edges and read data returns soon after.
`timescale 1ns/1ps
module lscs_host
   import lscs_pkg::*;
(
   input wire logic ref_clk,
   output lscs_req_t reg_req,
   input wire lscs_rsp_t reg_rsp
);
   initial reg_req = '0;

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      // Idle bus shows inverted values so stale data cannot pass as fresh
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge ref_clk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
      @(posedge ref_clk);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
      for (int i = 0; i < 4 && !ok; i++) begin
         #1;
         if (reg_rsp.valid === 1'b1) begin
            ok = 1'b1;
            d = reg_rsp.data;
         end else begin
            @(posedge ref_clk);
         end
      end
   endtask
endmodule // lscs_host

// file: bench/lscs_top_tb.sv
// Self-checking bench for the sink current bank, random codes with fixed corners.
// Assumes the host model in lscs_host and a 10 MHz reference clock.
`timescale 1ns/1ps
`define CHK(g, e) check((g) === (e), 32'(g))
module lscs_top_tb
   import lscs_pkg::*;
;
   logic ref_clk, reset, pin0;
   lscs_req_t reg_req;
   lscs_rsp_t reg_rsp;
   lscs_ctrl_t ctrl;
   lscs_sink_t fa, fb, fc, aa, ab, ac;
   logic [LSCS_UA_W-1:0] ftot;
   int num_errors, n_compared;
   logic [7:0] ofs [6] = '{8'h01, 8'h02, 8'h06, 8'h07, 8'h08, 8'h03};
   logic [7:0] c [5];

   lscs_host lscs_host_i (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rsp(reg_rsp));
   lscs_top lscs_top_i (.ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
      .reg_rsp(reg_rsp), .ctrl(ctrl), .general_pin0_preview_input(pin0),
      .flash_sink_a(fa), .flash_sink_b(fb), .flash_sink_c(fc), .aux_sink_a(aa),
      .aux_sink_b(ab), .aux_sink_c(ac), .flash_total_ua(ftot));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   function automatic logic [LSCS_UA_W-1:0] tot(input logic [7:0] k);
      return LSCS_UA_W'(int'(k) * LSCS_FULL_SCALE_UA / LSCS_CODE_STEPS);
   endfunction

   task automatic results();
      $display("errors %0d, comparisons %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input bit ok, input logic [31:0] got);
      n_compared++;
      if (!ok) begin
         num_errors++;
         $display("FAIL t=%0t value mismatch, got %h", $time, got);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      bit ok;
      lscs_host_i.rd(a, d, ok);
      if (!ok) begin
         num_errors++;
         $display("FAIL t=%0t read answer missing", $time);
         results();
      end
      `CHK(d, e);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic chk_flash(input logic [7:0] k, input logic en);
      `CHK(fa.on, en && k != 8'h00);
      if (en) begin
         `CHK(fa.level, k);
         `CHK(fb, fa);
         `CHK(fc, fa);
         `CHK(fa.ua, tot(k) / 3);
         `CHK(ftot, tot(k));
      end
   endtask

   task automatic chk_aux(input lscs_sink_t s, input logic [7:0] k, input logic open);
      `CHK(s.on, open && k != 8'h00);
      `CHK(s.level, k);
      if (s.on === 1'b1)
         `CHK(s.ua, tot(k));
   endtask

   task automatic chk_aux3(input logic open);
      chk_aux(aa, c[2], open);
      chk_aux(ab, c[3], open);
      chk_aux(ac, c[4], open);
   endtask

   initial begin
      reset = 1'b1;
      pin0 = 1'b0;
      ctrl = '0;
      num_errors = 0;
      n_compared = 0;
      void'($urandom(96));
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      foreach (ofs[i])
         rdchk(ofs[i], 8'h00);
      for (int it = 0; it < 6; it++) begin
         // Random aux codes stay below 64 so the enabled total keeps within the pump limit
         foreach (c[i])
            c[i] = (i < 2) ? 8'($urandom) : 8'($urandom % 64);
         if (it == 0)
            c = '{8'hFF, 8'h01, 8'hFF, 8'h00, 8'h00};
         if (it == 1)
            c = '{8'h00, 8'hFF, 8'h00, 8'h3F, 8'h01};
         foreach (c[i])
            lscs_host_i.wr(ofs[i], c[i]);
         lscs_host_i.wr(8'h03, 8'h77);
         foreach (c[i])
            rdchk(ofs[i], c[i]);
         rdchk(8'h03, 8'h00);
         ctrl <= '{preview_enable: 1'b1, default: 1'b0};
         settle(3);
         chk_flash(c[0], 1'b1);
         chk_aux3(1'b1);
         ctrl.strobe_active <= 1'b1;
         settle(3);
         chk_flash(c[1], 1'b1);
         ctrl <= '0;
         settle(3);
         chk_flash(c[0], 1'b0);
         ctrl.preview_pin_select <= 1'b1;
         pin0 <= 1'b1;
         settle(7);
         chk_flash(c[0], 1'b1);
         ctrl.preview_enable <= 1'b1;
         pin0 <= 1'b0;
         settle(7);
         chk_flash(c[0], 1'b0);
         ctrl <= '{aux_sinks_pin0_gate: 1'b1, default: 1'b0};
         settle(3);
         chk_aux3(1'b0);
         pin0 <= 1'b1;
         settle(7);
         chk_aux3(1'b1);
         ctrl <= '{aux_sinks_strobe_gate: 1'b1, default: 1'b0};
         pin0 <= 1'b0;
         settle(7);
         chk_aux3(1'b0);
         ctrl.strobe_active <= 1'b1;
         settle(3);
         chk_aux3(1'b1);
         ctrl <= '0;
      end
      results();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      $display("FAIL t=%0t run did not finish", $time);
      results();
   end
endmodule // lscs_top_tb
